// ==== src/spp_pkg.sv ====
// Constants and types shared by the serial port block
package spp_pkg;
  localparam int SPP_AW = 12;

  // Register indices; byte address is four times the index
  localparam logic [7:0] SPP_IDX_DATA = 8'h3C;
  localparam logic [7:0] SPP_IDX_CFG = 8'h3D;
  localparam logic [7:0] SPP_IDX_STS = 8'h3E;
  localparam logic [7:0] SPP_IDX_MASK = 8'h3F;
  localparam logic [7:0] SPP_IDX_PIN = 8'h40;
  localparam logic [11:0] SPP_ADDR_DATA = {2'b00, SPP_IDX_DATA, 2'b00};
  localparam logic [11:0] SPP_ADDR_CFG = {2'b00, SPP_IDX_CFG, 2'b00};
  localparam logic [11:0] SPP_ADDR_STS = {2'b00, SPP_IDX_STS, 2'b00};
  localparam logic [11:0] SPP_ADDR_MASK = {2'b00, SPP_IDX_MASK, 2'b00};
  localparam logic [11:0] SPP_ADDR_PIN = {2'b00, SPP_IDX_PIN, 2'b00};

  // Reset values
  localparam logic [7:0] SPP_DATA_RST = 8'h00;
  localparam logic [7:0] SPP_CFG_RST = 8'h00;
  localparam logic [1:0] SPP_STS_RST = 2'h0;
  localparam logic [1:0] SPP_MASK_RST = 2'h0;
  localparam logic [11:0] SPP_PIN_RST = 12'h000;

  // Configuration fields
  localparam int SPP_CFG_SWAP = 7;
  localparam int SPP_CFG_LSB = 6;
  localparam int SPP_CFG_MODE_HI = 5;
  localparam int SPP_CFG_MODE_LO = 4;
  localparam int SPP_CFG_CPOL = 3;
  localparam int SPP_CFG_CPHA = 2;
  localparam int SPP_CFG_RATE_HI = 1;
  localparam int SPP_CFG_RATE_LO = 0;

  // Status and mask bits
  localparam int SPP_STS_RX = 0;
  localparam int SPP_STS_TX = 1;

  // Pin control fields: output enables, data, alternate-function selects
  localparam int SPP_PIN_OE_LSB = 0;
  localparam int SPP_PIN_DAT_LSB = 4;
  localparam int SPP_PIN_ALT_LSB = 8;
  localparam int SPP_P_CLK = 0;
  localparam int SPP_P_SEL = 1;
  localparam int SPP_P_OUT = 2;
  localparam int SPP_P_IN = 3;

  // Serial clock divisors of the cpu clock and their half periods
  localparam int SPP_DIV_0 = 6;
  localparam int SPP_DIV_1 = 12;
  localparam int SPP_DIV_2 = 48;
  localparam int SPP_DIV_3 = 96;
  localparam logic [5:0] SPP_HALF_0 = 6'(SPP_DIV_0 / 2);
  localparam logic [5:0] SPP_HALF_1 = 6'(SPP_DIV_1 / 2);
  localparam logic [5:0] SPP_HALF_2 = 6'(SPP_DIV_2 / 2);
  localparam logic [5:0] SPP_HALF_3 = 6'(SPP_DIV_3 / 2);

  localparam logic [3:0] SPP_BITS = 4'h8;

  localparam logic [1:0] SPP_RESP_OKAY = 2'b00;
  localparam logic [1:0] SPP_RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    SPP_MODE_OFF = 2'b00,
    SPP_MODE_MASTER = 2'b01,
    SPP_MODE_SLAVE = 2'b10,
    SPP_MODE_RSVD = 2'b11
  } spp_mode_e;

  typedef enum logic {
    SPP_ST_IDLE = 1'b0,
    SPP_ST_SHIFT = 1'b1
  } spp_state_e;

  typedef enum logic [2:0] {
    SPP_SEL_NONE = 3'b000,
    SPP_SEL_DATA = 3'b001,
    SPP_SEL_CFG = 3'b010,
    SPP_SEL_STS = 3'b011,
    SPP_SEL_MASK = 3'b100,
    SPP_SEL_PIN = 3'b101
  } spp_sel_e;
endpackage

// ==== src/spp_half_tick.sv ====
// Half-period strobe generator for the master serial clock
`timescale 1ns/10ps
module spp_half_tick import spp_pkg::*; (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic run,
  input wire logic [1:0] rate_sel,
  // Strobe, one per serial clock half period
  output logic tick
);
  logic [5:0] cnt_q;
  logic [5:0] cnt_d;
  logic tick_q;
  logic tick_d;
  logic [5:0] half;

  always_comb begin
    unique case (rate_sel)
      2'b00: half = SPP_HALF_0;
      2'b01: half = SPP_HALF_1;
      2'b10: half = SPP_HALF_2;
      2'b11: half = SPP_HALF_3;
    endcase
    tick_d = 1'b0;
    cnt_d = cnt_q;
    if (!run) begin
      cnt_d = 6'h00;
    end else if (cnt_q >= half - 6'h01) begin
      // Compare by >= so a rate change mid-byte cannot stall the count
      cnt_d = 6'h00;
      tick_d = 1'b1;
    end else begin
      cnt_d = cnt_q + 6'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 6'h00;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;
endmodule

// ==== src/spp_port.sv ====
// Byte-wide serial peripheral port, master or slave, with AXI4-Lite registers
// Behaviour
// [R1] Data register reads return receive buffer; writes load transmit holding register.
// [R2] Interrupt on received byte available and on transmit holding register empty.
// [R3] Software must service buffers within seven serial clocks after the interrupt.
// [R4] Serial core steps only on serial clock edges, not system clock rate.
// [R5] Link uses four pins: clock, select, two data lines.
// [R6] Config bit 7 swaps the roles of the two data pins.
// [R7] Config bit 6 set shifts least significant bit first, else most.
// [R8] Mode field 5:4: 00 off, 01 master, 10 slave, 11 reserved.
// [R9] Config bit 3 sets serial clock idle level: clear low, set high.
// [R10] Config bit 2 picks the clock phase on which input is sampled.
// [R11] Master clock divides cpu clock by 6, 12, 48 or 96.
// [R12] In master or slave mode the logic sets select and data pin directions. The logic sets data pin directions only when their alternate bit is set.
// [R13] Clock pin direction is left to software: output for master, input slave.
// [R14] Enabled port drives select pin; disabled, general-purpose bits control it. The logic drives it in master mode only; in slave mode its enable is held off.
// [R15] Clock and data pins serial-driven only if enabled and alternate bit set.
// [R16] Exactly eight bits per byte; phase clear samples leading edge; reserved means off.
// [R17] Data and configuration registers reset to zero, so the port starts disabled.
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/10ps
module spp_port import spp_pkg::*; (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [SPP_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [SPP_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupt
  output logic irq,
  // Serial clock pin
  input wire logic port1_clock_pin_i,
  output logic port1_clock_pin_o,
  output logic port1_clock_pin_oe,
  // Select pin, active low on the link
  input wire logic port1_select_pin_i,
  output logic port1_select_pin_o,
  output logic port1_select_pin_oe,
  // Master-out data pin
  input wire logic out_data_pin_i,
  output logic out_data_pin_o,
  output logic out_data_pin_oe,
  // Master-in data pin
  input wire logic in_data_pin_i,
  output logic in_data_pin_o,
  output logic in_data_pin_oe
);
  function automatic spp_sel_e dec(input logic [SPP_AW-1:0] a);
    case (a)
      SPP_ADDR_DATA: dec = SPP_SEL_DATA;
      SPP_ADDR_CFG: dec = SPP_SEL_CFG;
      SPP_ADDR_STS: dec = SPP_SEL_STS;
      SPP_ADDR_MASK: dec = SPP_SEL_MASK;
      SPP_ADDR_PIN: dec = SPP_SEL_PIN;
      default: dec = SPP_SEL_NONE;
    endcase
  endfunction

  // Register state
  logic [7:0] cfg_q, cfg_d, txh_q, txh_d, rxbuf_q, rxbuf_d;
  logic txfull_q, txfull_d;
  logic [1:0] sts_q, sts_d, mask_q, mask_d;
  logic [11:0] pin_q, pin_d;
  logic irq_q, irq_d;
  // Bus state
  logic awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
  logic arready_q, arready_d, rvalid_q, rvalid_d;
  logic aw_got_q, aw_got_d, w_got_q, w_got_d;
  logic [SPP_AW-1:0] awaddr_q, awaddr_d;
  logic [11:0] wbyte_q, wbyte_d;
  logic wstrb0_q, wstrb0_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic wr_go;
  spp_sel_e wsel;
  spp_sel_e rsel;
  // Engine state
  spp_state_e st_q, st_d;
  logic [7:0] sh_q, sh_d, rxs_q, rxs_d;
  logic [3:0] bits_q, bits_d;
  logic sclk_q, sclk_d;
  logic load_tx, rx_evt;
  // Pin state
  logic [3:0] sync1_q, sync2_q;
  logic sclk_p_q;
  logic clk_o_q, clk_o_d, clk_oe_q, clk_oe_d, sel_o_q, sel_o_d, sel_oe_q, sel_oe_d;
  logic mo_o_q, mo_o_d, mo_oe_q, mo_oe_d, mi_o_q, mi_o_d, mi_oe_q, mi_oe_d;

  spp_mode_e mode;
  logic en, is_master, is_slave, lsb, cpol, cpha, swap;
  logic tick, lead, trail, sample, shift_ev, sel_act, tx_on_out, rx_bit, tx_bit, drv;

  assign mode = spp_mode_e'(cfg_q[SPP_CFG_MODE_HI:SPP_CFG_MODE_LO]);
  assign is_master = (mode == SPP_MODE_MASTER);  // [R8]
  assign is_slave = (mode == SPP_MODE_SLAVE);  // [R8]
  assign en = is_master || is_slave;  // [R16]
  assign lsb = cfg_q[SPP_CFG_LSB];
  assign cpol = cfg_q[SPP_CFG_CPOL];
  assign cpha = cfg_q[SPP_CFG_CPHA];
  assign swap = cfg_q[SPP_CFG_SWAP];

  spp_half_tick u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(is_master && (st_q == SPP_ST_SHIFT)),
    .rate_sel(cfg_q[SPP_CFG_RATE_HI:SPP_CFG_RATE_LO]),  // [R11]
    .tick(tick)
  );

  // Pin inputs come from off chip, so two flops before any use
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
      sclk_p_q <= 1'b0;
    end else begin
      sync1_q <= {in_data_pin_i, out_data_pin_i, port1_select_pin_i, port1_clock_pin_i};
      sync2_q <= sync1_q;
      sclk_p_q <= sync2_q[SPP_P_CLK];
    end
  end

  assign sel_act = !sync2_q[SPP_P_SEL];
  assign tx_on_out = is_master ^ swap;  // [R6]
  assign rx_bit = tx_on_out ? sync2_q[SPP_P_IN] : sync2_q[SPP_P_OUT];  // [R6]
  assign tx_bit = lsb ? sh_q[0] : sh_q[7];  // [R7]
  assign drv = is_master || sel_act;

  // Leading edge leaves the idle level, trailing edge returns to it
  always_comb begin
    lead = 1'b0;
    trail = 1'b0;
    if (st_q == SPP_ST_SHIFT) begin
      if (is_master) begin
        lead = tick && (sclk_q == cpol);  // [R4] [R9]
        trail = tick && (sclk_q != cpol);  // [R4]
      end else begin
        lead = (sync2_q[SPP_P_CLK] != sclk_p_q) && (sclk_p_q == cpol);  // [R4] [R9]
        trail = (sync2_q[SPP_P_CLK] != sclk_p_q) && (sclk_p_q != cpol);  // [R4]
      end
    end
    sample = cpha ? trail : lead;  // [R10] [R16]
    // With phase set the first bit is already on the line from the load
    shift_ev = cpha ? (lead && (bits_q != 4'h0)) : trail;  // [R10]
  end

  // Shift engine
  always_comb begin
    st_d = st_q;
    sh_d = sh_q;
    rxs_d = rxs_q;
    bits_d = bits_q;
    sclk_d = sclk_q;
    rxbuf_d = rxbuf_q;
    load_tx = 1'b0;
    rx_evt = 1'b0;
    if (!en) begin
      st_d = SPP_ST_IDLE;  // [R8] [R16]
      bits_d = 4'h0;
      sclk_d = cpol;  // [R9]
    end else begin
      unique case (st_q)
        SPP_ST_IDLE: begin
          sclk_d = cpol;  // [R9]
          bits_d = 4'h0;
          if ((is_master && txfull_q) || (is_slave && sel_act)) begin
            st_d = SPP_ST_SHIFT;
            // A slave with nothing written resends the last byte
            sh_d = txh_q;
            load_tx = txfull_q;  // [R2]
          end
        end
        SPP_ST_SHIFT: begin
          if (is_master && tick) begin
            sclk_d = ~sclk_q;  // [R11]
          end
          if (is_slave && !sel_act) begin
            st_d = SPP_ST_IDLE;
          end else begin
            if (sample) begin
              bits_d = bits_q + 4'h1;
              rxs_d = lsb ? {rx_bit, rxs_q[7:1]} : {rxs_q[6:0], rx_bit};  // [R7]
            end
            if (shift_ev) begin
              sh_d = lsb ? {1'b0, sh_q[7:1]} : {sh_q[6:0], 1'b0};  // [R7]
            end
            if (trail && (bits_d == SPP_BITS)) begin
              st_d = SPP_ST_IDLE;  // [R16]
              rxbuf_d = rxs_d;
              rx_evt = 1'b1;  // [R2]
            end
          end
        end
      endcase
    end
  end

  // Pin drive
  always_comb begin
    clk_oe_d = pin_q[SPP_PIN_OE_LSB + SPP_P_CLK];  // [R13]
    clk_o_d = pin_q[SPP_PIN_DAT_LSB + SPP_P_CLK];
    if (is_master && pin_q[SPP_PIN_ALT_LSB + SPP_P_CLK]) begin
      clk_o_d = sclk_q;  // [R15]
    end
    sel_oe_d = pin_q[SPP_PIN_OE_LSB + SPP_P_SEL];
    sel_o_d = pin_q[SPP_PIN_DAT_LSB + SPP_P_SEL];
    if (en) begin
      sel_oe_d = is_master;  // [R12] [R14]
      sel_o_d = (st_q != SPP_ST_SHIFT);  // [R14]
    end
    mo_oe_d = pin_q[SPP_PIN_OE_LSB + SPP_P_OUT];
    mo_o_d = pin_q[SPP_PIN_DAT_LSB + SPP_P_OUT];
    if (en && pin_q[SPP_PIN_ALT_LSB + SPP_P_OUT]) begin
      mo_oe_d = tx_on_out && drv;  // [R12] [R15]
      mo_o_d = tx_bit;
    end
    mi_oe_d = pin_q[SPP_PIN_OE_LSB + SPP_P_IN];
    mi_o_d = pin_q[SPP_PIN_DAT_LSB + SPP_P_IN];
    if (en && pin_q[SPP_PIN_ALT_LSB + SPP_P_IN]) begin
      mi_oe_d = !tx_on_out && drv;  // [R12] [R15]
      mi_o_d = tx_bit;
    end
  end

  // Bus slave and registers
  assign wsel = dec(awaddr_q);
  assign rsel = dec(s_axi_araddr);

  always_comb begin
    aw_got_d = aw_got_q;
    w_got_d = w_got_q;
    awaddr_d = awaddr_q;
    wbyte_d = wbyte_q;
    wstrb0_d = wstrb0_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    arready_d = arready_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    wr_go = 1'b0;
    if (s_axi_awvalid && awready_q) begin
      aw_got_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin
      w_got_d = 1'b1;
      // Alternate-function bits are written only through byte lane 1
      wbyte_d = {s_axi_wstrb[1] ? s_axi_wdata[11:8] : pin_q[11:8], s_axi_wdata[7:0]};  // [R15]
      wstrb0_d = s_axi_wstrb[0];
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (aw_got_q && w_got_q && !bvalid_q) begin
      wr_go = 1'b1;
      aw_got_d = 1'b0;
      w_got_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = (wsel == SPP_SEL_NONE) ? SPP_RESP_SLVERR : SPP_RESP_OKAY;
    end
    awready_d = !aw_got_d && !bvalid_d;
    wready_d = !w_got_d && !bvalid_d;
    if (s_axi_arvalid && arready_q) begin
      arready_d = 1'b0;
      rvalid_d = 1'b1;
      rresp_d = (rsel == SPP_SEL_NONE) ? SPP_RESP_SLVERR : SPP_RESP_OKAY;
      unique case (rsel)
        SPP_SEL_DATA: rdata_d = {24'h00_0000, rxbuf_q};  // [R1]
        SPP_SEL_CFG: rdata_d = {24'h00_0000, cfg_q};
        SPP_SEL_STS: rdata_d = {30'h0000_0000, sts_q};
        SPP_SEL_MASK: rdata_d = {30'h0000_0000, mask_q};
        SPP_SEL_PIN: rdata_d = {20'h0_0000, pin_q};
        default: rdata_d = 32'h0000_0000;
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
      arready_d = 1'b1;
    end
  end

  always_comb begin
    cfg_d = cfg_q;
    txh_d = txh_q;
    mask_d = mask_q;
    pin_d = pin_q;
    sts_d = sts_q;
    if (wr_go && wstrb0_q) begin
      unique case (wsel)
        SPP_SEL_DATA: txh_d = wbyte_q[7:0];  // [R1] [R3]
        SPP_SEL_CFG: cfg_d = wbyte_q[7:0];
        SPP_SEL_STS: sts_d = sts_q & ~wbyte_q[1:0];
        SPP_SEL_MASK: mask_d = wbyte_q[1:0];
        SPP_SEL_PIN: pin_d = wbyte_q;  // [R15]
        default: cfg_d = cfg_q;
      endcase
    end
    // A fresh write beats the load that empties the holding register
    txfull_d = (txfull_q && !load_tx) || (wr_go && wstrb0_q && (wsel == SPP_SEL_DATA));  // [R1]
    // Hardware events win over a same-cycle write-one-to-clear
    sts_d[SPP_STS_RX] = sts_d[SPP_STS_RX] | rx_evt;  // [R2]
    sts_d[SPP_STS_TX] = sts_d[SPP_STS_TX] | load_tx;  // [R2]
    irq_d = |(sts_d & mask_d);  // [R2]
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q <= SPP_CFG_RST;  // [R17]
      txh_q <= SPP_DATA_RST;  // [R17]
      rxbuf_q <= SPP_DATA_RST;  // [R17]
      txfull_q <= 1'b0;
      sts_q <= SPP_STS_RST;
      mask_q <= SPP_MASK_RST;
      pin_q <= SPP_PIN_RST;
      irq_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= '0;
      wbyte_q <= 12'h000;
      wstrb0_q <= 1'b0;
      bresp_q <= SPP_RESP_OKAY;
      rresp_q <= SPP_RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      st_q <= SPP_ST_IDLE;
      sh_q <= 8'h00;
      rxs_q <= 8'h00;
      bits_q <= 4'h0;
      sclk_q <= 1'b0;
      clk_o_q <= 1'b0;
      clk_oe_q <= 1'b0;
      sel_o_q <= 1'b0;
      sel_oe_q <= 1'b0;
      mo_o_q <= 1'b0;
      mo_oe_q <= 1'b0;
      mi_o_q <= 1'b0;
      mi_oe_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      txh_q <= txh_d;
      rxbuf_q <= rxbuf_d;
      txfull_q <= txfull_d;
      sts_q <= sts_d;
      mask_q <= mask_d;
      pin_q <= pin_d;
      irq_q <= irq_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      arready_q <= arready_d | (!arready_q && !rvalid_q);
      rvalid_q <= rvalid_d;
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      awaddr_q <= awaddr_d;
      wbyte_q <= wbyte_d;
      wstrb0_q <= wstrb0_d;
      bresp_q <= bresp_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      st_q <= st_d;
      sh_q <= sh_d;
      rxs_q <= rxs_d;
      bits_q <= bits_d;
      sclk_q <= sclk_d;
      clk_o_q <= clk_o_d;  // [R5]
      clk_oe_q <= clk_oe_d;
      sel_o_q <= sel_o_d;  // [R5]
      sel_oe_q <= sel_oe_d;
      mo_o_q <= mo_o_d;  // [R5]
      mo_oe_q <= mo_oe_d;
      mi_o_q <= mi_o_d;  // [R5]
      mi_oe_q <= mi_oe_d;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign irq = irq_q;
  assign port1_clock_pin_o = clk_o_q;
  assign port1_clock_pin_oe = clk_oe_q;
  assign port1_select_pin_o = sel_o_q;
  assign port1_select_pin_oe = sel_oe_q;
  assign out_data_pin_o = mo_o_q;
  assign out_data_pin_oe = mo_oe_q;
  assign in_data_pin_o = mi_o_q;
  assign in_data_pin_oe = mi_oe_q;
endmodule

// ==== testbench/spp_port_checker.sv ====
// Bus and pin checker for the serial port block
`timescale 1ns/10ps
module spp_port_checker (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupt and pins
  input wire logic irq,
  input wire logic port1_select_pin_o,
  input wire logic port1_select_pin_oe,
  input wire logic out_data_pin_oe,
  input wire logic in_data_pin_oe
);
  logic [9:0] low_q;
  logic [9:0] low_d;
  logic [2:0] age_q;
  logic [2:0] age_d;

  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Select low count assumes general-purpose use never parks select low
  always_comb begin
    low_d = 10'h000;
    if (port1_select_pin_oe && !port1_select_pin_o) begin
      low_d = low_q + 10'h001;
    end
    age_d = age_q;
    if (s_axi_wvalid && s_axi_wready) begin
      age_d = 3'h0;
    end else if (age_q != 3'h7) begin
      age_d = age_q + 3'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_q <= 10'h000;
      age_q <= 3'h7;
    end else begin
      low_q <= low_d;
      age_q <= age_d;
    end
  end

  property p_rd_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_rd_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
  property p_wr_resp;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_rst;
    $rose(aresetn) |-> !irq && !port1_select_pin_oe && !out_data_pin_oe && !in_data_pin_oe;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs active after reset");
  property p_sel_max;
    low_q <= 10'h384;
  endproperty
  a_sel_max: assert property (p_sel_max) else $error("frame too long");
  property p_sel_min;
    $rose(port1_select_pin_o) && $past(port1_select_pin_oe) |-> low_q >= 10'h030;
  endproperty
  a_sel_min: assert property (p_sel_min) else $error("frame too short");
  property p_pin_quiet;
    $changed(out_data_pin_oe) || $changed(in_data_pin_oe) |-> age_q < 3'h6;
  endproperty
  a_pin_quiet: assert property (p_pin_quiet) else $error("data pin taken over");
endmodule

// ==== testbench/spp_link_peer.sv ====
// Behavioural far-end serial master for slave mode
`timescale 1ns/10ps
module spp_link_peer #(
  parameter int HALF = 8
) (
  // Clock
  input wire logic aclk,
  // Link lines toward the port
  output logic sclk,
  output logic sel_n,
  output logic mosi
);
  initial begin
    sclk = 1'b0;
    sel_n = 1'b1;
    mosi = 1'b0;
  end

  // Most significant bit first; clock stands still outside frames
  task automatic send(input logic [7:0] b, input logic cpol, input logic cpha);
    sclk <= cpol;
    repeat (2 * HALF) @(posedge aclk);
    mosi <= b[7];
    sel_n <= 1'b0;
    repeat (HALF) @(posedge aclk);
    for (int i = 7; i >= 0; i--) begin
      sclk <= ~cpol;
      if (cpha) mosi <= b[i];
      repeat (HALF) @(posedge aclk);
      sclk <= cpol;
      if (!cpha && i > 0) mosi <= b[i-1];
      repeat (HALF) @(posedge aclk);
    end
    sel_n <= 1'b1;
    // Released line must not keep a stale bit
    mosi <= ~mosi;
    repeat (2 * HALF) @(posedge aclk);
  endtask
endmodule

// ==== testbench/spi_master_slave_port_test.sv ====
// Self-checking bench for the serial port block
`timescale 1ns/10ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin err_count++; \
  $display("CHECK FAILED at %0t: got %h expected %h", $time, (a), (e)); end end
module spi_master_slave_port_test import spp_pkg::*;;
  logic aclk;
  logic aresetn;
  logic [SPP_AW-1:0] s_axi_awaddr;
  logic [SPP_AW-1:0] s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [31:0] s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp;
  logic [1:0] s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
  logic port1_clock_pin_i, port1_clock_pin_o, port1_clock_pin_oe;
  logic port1_select_pin_i, port1_select_pin_o, port1_select_pin_oe;
  logic out_data_pin_i, out_data_pin_o, out_data_pin_oe;
  logic in_data_pin_i, in_data_pin_o, in_data_pin_oe;
  logic sclk, sel_n, mosi, swap;
  int err_count, total_checks, cyc;

  assign port1_clock_pin_i = sclk;
  assign port1_select_pin_i = sel_n;
  // Idle data line carries the inverse so a wrong pin choice shows
  assign out_data_pin_i = swap ? ~mosi : mosi;
  assign in_data_pin_i = swap ? mosi : ~mosi;

  spp_link_peer #(.HALF(8)) u_peer (.aclk(aclk), .sclk(sclk), .sel_n(sel_n), .mosi(mosi));
  spp_port u_dut (.*);

  always #5 aclk = ~aclk;

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      print_verdict();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bresp, er)
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
    `CHK(s_axi_rresp, er)
  endtask

  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    logic [31:0] d;
    rd(a, d, SPP_RESP_OKAY);
    `CHK(d, {24'h00_0000, e})
  endtask

  task automatic t_reset_regs;
    logic [31:0] d;
    rchk(SPP_ADDR_DATA, 8'h00);
    rchk(SPP_ADDR_CFG, 8'h00);
    rchk(SPP_ADDR_STS, 8'h00);
    rchk(SPP_ADDR_MASK, 8'h00);
    rchk(SPP_ADDR_PIN, 8'h00);
    wr(SPP_ADDR_DATA, 8'h77, SPP_RESP_OKAY);
    tick(4);
    rchk(SPP_ADDR_DATA, 8'h00);
    wr(12'h200, 8'h01, SPP_RESP_SLVERR);
    rd(12'h200, d, SPP_RESP_SLVERR);
  endtask

  task automatic t_config;
    logic [7:0] v [4];
    v = '{8'h8F, 8'h59, 8'hA6, 8'hF3};
    foreach (v[i]) begin
      wr(SPP_ADDR_CFG, v[i], SPP_RESP_OKAY);
      tick(3);
      rchk(SPP_ADDR_CFG, v[i]);
      `CHK(port1_select_pin_oe, v[i][5:4] == 2'b01)
    end
    wr(SPP_ADDR_CFG, 8'h00, SPP_RESP_OKAY);
  endtask

  task automatic t_gpio;
    wr(SPP_ADDR_PIN, 8'hBD, SPP_RESP_OKAY);
    tick(3);
    `CHK({port1_clock_pin_oe, port1_clock_pin_o, port1_select_pin_oe, out_data_pin_oe, out_data_pin_o,
          in_data_pin_oe, in_data_pin_o}, 7'h6B)
    rchk(SPP_ADDR_PIN, 8'hBD);
    wr(SPP_ADDR_CFG, 8'h90, SPP_RESP_OKAY);
    tick(3);
    `CHK({port1_select_pin_oe, port1_select_pin_o, out_data_pin_oe, out_data_pin_o, in_data_pin_oe,
          in_data_pin_o}, 6'h3B)
    wr(SPP_ADDR_CFG, 8'h00, SPP_RESP_OKAY);
    wr(SPP_ADDR_PIN, 8'h00, SPP_RESP_OKAY);
  endtask

  task automatic t_master;
    int n;
    int div [4];
    div = '{SPP_DIV_0, SPP_DIV_1, SPP_DIV_2, SPP_DIV_3};
    // Clock pin direction is left to software in master mode
    wr(SPP_ADDR_PIN, 8'h01, SPP_RESP_OKAY);
    wr(SPP_ADDR_STS, 8'h03, SPP_RESP_OKAY);
    for (int r = 0; r < 4; r++) begin
      wr(SPP_ADDR_MASK, r[0] ? 8'h00 : 8'h03, SPP_RESP_OKAY);
      wr(SPP_ADDR_CFG, 8'h10 | 8'(r), SPP_RESP_OKAY);
      wr(SPP_ADDR_DATA, 8'hA5, SPP_RESP_OKAY);
      n = 0;
      while (port1_select_pin_o !== 1'b0 && n < 40) begin
        tick(1);
        n++;
      end
      n = 0;
      while (port1_select_pin_o === 1'b0 && n < 1000) begin
        tick(1);
        n++;
      end
      `CHK(n >= div[r] * 8 && n <= div[r] * 10 + 8, 1'b1)
      tick(4);
      `CHK(irq, !r[0])
      rchk(SPP_ADDR_STS, 8'h03);
      wr(SPP_ADDR_STS, 8'h03, SPP_RESP_OKAY);
      tick(2);
      `CHK(irq, 1'b0)
    end
    wr(SPP_ADDR_CFG, 8'h00, SPP_RESP_OKAY);
    wr(SPP_ADDR_MASK, 8'h00, SPP_RESP_OKAY);
    wr(SPP_ADDR_PIN, 8'h00, SPP_RESP_OKAY);
  endtask

  task automatic t_slave;
    logic [2:0] m;
    logic [7:0] b;
    logic [7:0] e;
    logic [31:0] d;
    for (int k = 0; k < 8; k++) begin
      m = 3'(k);
      b = 8'hC5 ^ {m, 5'h00};
      swap <= ^m;
      wr(SPP_ADDR_CFG, {^m, m[2], 2'b10, m[1:0], 2'b00}, SPP_RESP_OKAY);
      tick(3);
      `CHK({port1_select_pin_oe, out_data_pin_oe, in_data_pin_oe}, 3'h0)
      u_peer.send(b, m[1], m[0]);
      e = b;
      if (m[2]) e = {<<{b}};
      rd(SPP_ADDR_STS, d, SPP_RESP_OKAY);
      `CHK(d[0], 1'b1)
      // Buffer emptied well before any next frame could start
      rchk(SPP_ADDR_DATA, e);
      wr(SPP_ADDR_STS, 8'h03, SPP_RESP_OKAY);
    end
    swap <= 1'b0;
    wr(SPP_ADDR_CFG, 8'h00, SPP_RESP_OKAY);
  endtask

  task automatic print_verdict;
    if (err_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    swap = 1'b0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'h1;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    tick(2);
    aresetn <= 1'b1;
    tick(3);
    t_reset_regs();
    t_config();
    t_gpio();
    t_master();
    t_slave();
    print_verdict();
  end
endmodule

bind spp_port spp_port_checker u_chk (.*);
